// [logic/impl_pkg.sv]
// constants and helpers shared by both ends of the mask and program loader
package impl_pkg;
	// device control addresses
	localparam logic [7:0] ADDR_PROG = 8'hC8;
	localparam logic [7:0] ADDR_MASK = 8'hCE;
	localparam logic [7:0] ADDR_TEST = 8'hCF;
	// interrupt mask bit positions
	localparam int unsigned MB_MASTER = 15;
	localparam int unsigned MB_TONE = 12;
	localparam int unsigned MB_AUX2 = 9;
	localparam int unsigned MB_AUX1 = 8;
	localparam int unsigned MB_TXEND = 7;
	localparam int unsigned MB_XFER = 6;
	localparam int unsigned MB_CRC = 5;
	localparam int unsigned MB_R2400 = 4;
	localparam int unsigned MB_R1200 = 3;
	localparam int unsigned MB_PRG = 0;
	localparam logic [15:0] SRC_MASK = 16'h13F9;
	localparam logic [15:0] LOAD_KEEP = 16'h8001;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	// programming word layout
	localparam int unsigned PB_SELECT_BIT = 15;
	localparam int unsigned PB_RAMP_BIT = 10;
	localparam logic [3:0] BLK_WORDS = 4'hC;
	localparam logic [3:0] BLK4_WORDS = 4'hE;
	localparam logic [3:0] RAMP_START = 4'hB;
	localparam logic [3:0] PTR_NONE = 4'hF;
	localparam logic [2:0] BLK_FOUR = 3'h4;
	localparam logic [2:0] BLK_RAMP = 3'h3;
	localparam logic [5:0] PB_WORDS = 6'h3E;
	localparam logic [15:0] PB_RESET = 16'h0000;
	// timing
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned PROG_TIME_US = 250;
	localparam int unsigned PROG_CYCLES = PROG_TIME_US * 1000000 / CLK_PERIOD_PS;
	// host register byte addresses
	localparam logic [3:0] HR_MASK = 4'h0;
	localparam logic [3:0] HR_PROG = 4'h4;
	localparam logic [3:0] HR_STAT = 4'h8;
	localparam logic [3:0] HR_CTRL = 4'hC;

	function automatic logic [2:0] pb_block(input logic [15:0] w);
		return w[14] ? {1'b0, w[13:12]} : BLK_FOUR;
	endfunction : pb_block

	function automatic logic [3:0] pb_len(input logic [2:0] b);
		return (b == BLK_FOUR) ? BLK4_WORDS : BLK_WORDS;
	endfunction : pb_len

	function automatic logic [3:0] pb_start(input logic [15:0] w);
		return (pb_block(w) == BLK_RAMP && w[PB_RAMP_BIT]) ? RAMP_START : 4'h0;
	endfunction : pb_start

	function automatic logic [5:0] pb_index(input logic [2:0] b, input logic [3:0] p);
		// widen before the product, or blocks 2 to 4 fold onto low indices
		return 6'(b) * 6'(BLK_WORDS) + {2'h0, p};
	endfunction : pb_index
endpackage : impl_pkg

// [logic/impl_link_if.sv]
// word-level control link between host and device
`timescale 1ns/1ps
interface impl_link_if;
	logic wr;
	logic rd_clr;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] status;
	logic idle;
	logic aux_on;
	logic irq_n;
	modport dev(input wr, input rd_clr, input addr, input wdata,
		output status, output idle, output aux_on, output irq_n);
	modport host(output wr, output rd_clr, output addr, output wdata,
		input status, input idle, input aux_on, input irq_n);
endinterface : impl_link_if

// [logic/impl_block_store.sv]
// flip-flop storage for the five program blocks
`timescale 1ns/1ps
module impl_block_store (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// write port
	input wire logic we,
	input wire logic [5:0] widx,
	input wire logic [15:0] wdata,
	// read port
	input wire logic [5:0] ridx,
	output logic [15:0] rdata
);
	logic [15:0] mem_r [0:61];
	wire ridx_ok = ridx < impl_pkg::PB_WORDS;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 62; i++) begin
				mem_r[i] <= impl_pkg::PB_RESET;
			end
		// untouched words keep their value
		end else if (we && widx < impl_pkg::PB_WORDS) begin
			mem_r[widx] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= impl_pkg::PB_RESET;
		end else begin
			rdata <= ridx_ok ? mem_r[ridx] : impl_pkg::PB_RESET;
		end
	end
endmodule : impl_block_store

// [logic/impl_device.sv]
// device end: interrupt mask, event flags, irq output and program block loader
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
//
// Contract
// - master bit gates every interrupt
// - bit 12 enables tone detect interrupt
// - bits 9,8 enable aux status change
// - bit 7 enables modem transmit end
// - bit 6 enables modem word request
// - bit 5 enables bad crc interrupt
// - bits 4,3 enable 2400/1200 data detect
// - bit 0 interrupts on ready rising
// - host never touches test address
// - loading accepted only in idle mode
// - host checks ready, idle, aux off first
// - host quiets sources during loading (host only cuts mask writes made while loading to bits 15 and 0)
// - write clears ready, set when done
// - host never writes while not ready (host still sends mask writes while ready is low)
// - host writes block words in order
// - unwritten words keep their values
// - host respects block word maxima
// - bit 15 selects block, resets pointer
// - plain words store and advance pointer
// - block 3 with bit 10 skips eleven
// - host rechecks ready after last word
module impl_device #(
	parameter int unsigned PROG_CYCLES = impl_pkg::PROG_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link to host
	impl_link_if.dev link,
	// operating mode
	input wire logic rx_enable,
	input wire logic tx_enable,
	input wire logic aux_enable,
	// event sources
	input wire logic tone_detect,
	input wire logic aux_converter_one,
	input wire logic aux_converter_two,
	input wire logic modem_tx_end,
	input wire logic modem_word_req,
	input wire logic crc_fail,
	input wire logic rate_2400_detect,
	input wire logic rate_1200_detect,
	// program block readback
	input wire logic [2:0] rd_block,
	input wire logic [3:0] rd_word,
	output logic [15:0] rd_data,
	// state
	output logic [15:0] mask_value,
	output logic loader_busy
);
	logic [15:0] mask_r;
	logic [15:0] pend_r;
	logic [15:0] pend_nxt;
	logic [15:0] cnt_r;
	logic ready_r;
	logic irq_n_r;
	logic aux1_q_r;
	logic aux2_q_r;
	logic [2:0] blk_r;
	logic [3:0] ptr_r;
	logic [15:0] ev;

	// decode of link writes
	wire wr_prog = link.wr && link.addr == impl_pkg::ADDR_PROG;
	wire wr_mask = link.wr && link.addr == impl_pkg::ADDR_MASK;
	wire dev_idle = !rx_enable && !tx_enable;
	wire prog_ok = wr_prog && dev_idle && ready_r;
	wire hdr = link.wdata[impl_pkg::PB_SELECT_BIT];
	wire [2:0] hdr_blk = impl_pkg::pb_block(link.wdata);
	wire [3:0] hdr_start = impl_pkg::pb_start(link.wdata);
	wire ptr_in = ptr_r < impl_pkg::pb_len(blk_r);
	wire store = prog_ok && (hdr || ptr_in);
	wire [5:0] widx = hdr ? impl_pkg::pb_index(hdr_blk, hdr_start)
		: impl_pkg::pb_index(blk_r, ptr_r);
	wire done = !ready_r && cnt_r == 16'h0000;
	wire aux1_chg = aux_converter_one != aux1_q_r;
	wire aux2_chg = aux_converter_two != aux2_q_r;
	wire [15:0] src_en = mask_r & impl_pkg::SRC_MASK;
	wire [15:0] clr = link.rd_clr ? 16'hFFFF : 16'h0000;

	// event vector laid out on the mask bits
	always_comb begin
		ev = 16'h0000;
		ev[impl_pkg::MB_TONE] = tone_detect;
		ev[impl_pkg::MB_AUX2] = aux2_chg;
		ev[impl_pkg::MB_AUX1] = aux1_chg;
		ev[impl_pkg::MB_TXEND] = modem_tx_end;
		ev[impl_pkg::MB_XFER] = modem_word_req;
		ev[impl_pkg::MB_CRC] = crc_fail;
		ev[impl_pkg::MB_R2400] = rate_2400_detect;
		ev[impl_pkg::MB_R1200] = rate_1200_detect;
		ev[impl_pkg::MB_PRG] = done;
	end

	// disabled sources never latch; set wins over a clear in the same cycle
	assign pend_nxt = (pend_r & ~clr) | (ev & src_en);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mask_r <= impl_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_r <= link.wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend_r <= 16'h0000;
			aux1_q_r <= 1'b0;
			aux2_q_r <= 1'b0;
		end else begin
			pend_r <= pend_nxt;
			aux1_q_r <= aux_converter_one;
			aux2_q_r <= aux_converter_two;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= !(mask_r[impl_pkg::MB_MASTER] && |(pend_r & src_en));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ready_r <= 1'b1;
			cnt_r <= 16'h0000;
		end else if (prog_ok) begin
			ready_r <= 1'b0;
			cnt_r <= 16'(PROG_CYCLES - 1);
		end else if (done) begin
			ready_r <= 1'b1;
		end else if (!ready_r) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

	// pointer: nothing is stored until a block is selected
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			blk_r <= impl_pkg::BLK_FOUR;
			ptr_r <= impl_pkg::PTR_NONE;
		end else if (prog_ok && hdr) begin
			blk_r <= hdr_blk;
			ptr_r <= hdr_start + 4'h1;
		end else if (store) begin
			ptr_r <= ptr_r + 4'h1;
		end
	end

	impl_block_store u_store (
		.clk(clk),
		.rstn(rstn),
		.we(store),
		.widx(widx),
		.wdata(link.wdata),
		.ridx(impl_pkg::pb_index(rd_block, rd_word)),
		.rdata(rd_data)
	);

	// status word: pending flags, bit 0 shows the ready level
	assign link.status = {pend_r[15:1], ready_r};
	assign link.idle = dev_idle;
	assign link.aux_on = aux_enable;
	assign link.irq_n = irq_n_r;
	assign mask_value = mask_r;
	assign loader_busy = !ready_r;
endmodule : impl_device

// [logic/impl_host.sv]
// host end: avalon-mm register slave that drives the control link
`timescale 1ns/1ps
module impl_host (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// link to device
	impl_link_if.host link
);
	logic wr_r;
	logic rdclr_r;
	logic [7:0] addr_r;
	logic [15:0] wdata_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic loading_r;
	logic err_r;
	logic [15:0] mask_r;
	logic [2:0] blk_r;
	logic [3:0] cnt_r;
	logic [3:0] max_r;

	wire sel_mask = avs_address == impl_pkg::HR_MASK;
	wire sel_prog = avs_address == impl_pkg::HR_PROG;
	wire sel_stat = avs_address == impl_pkg::HR_STAT;
	wire sel_ctrl = avs_address == impl_pkg::HR_CTRL;
	wire [15:0] wd = avs_writedata[15:0];
	wire ready = link.status[0];
	wire hdr = wd[impl_pkg::PB_SELECT_BIT];
	wire wait_w = wr_r || ((sel_prog || sel_ctrl) && !ready);
	assign avs_waitrequest = avs_read ? !rvalid_r : (avs_write && wait_w);
	wire wr_take = avs_write && !avs_waitrequest;
	// idle and aux off; word maxima
	wire prog_bad = !link.idle || link.aux_on || (!hdr && cnt_r >= max_r);
	wire send_prog = wr_take && sel_prog && !prog_bad;
	wire send_mask = wr_take && sel_mask;
	// other sources cut from mask writes made while loading
	wire [15:0] mask_out = loading_r ? (wd & impl_pkg::LOAD_KEEP) : wd;
	wire rd_take = avs_read && !rvalid_r;
	wire [31:0] stat_word = {11'h000, err_r, loading_r, !link.irq_n,
		link.aux_on, link.idle, link.status};
	wire [31:0] rmux = sel_mask ? {16'h0000, mask_r}
		: sel_stat ? stat_word
		: sel_ctrl ? {30'h0, err_r, loading_r} : 32'h0000_0000;

	// only the two working addresses are ever sent
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_r <= 1'b0;
			addr_r <= impl_pkg::ADDR_MASK;
			wdata_r <= 16'h0000;
		end else begin
			wr_r <= send_prog || send_mask;
			if (send_prog) begin
				addr_r <= impl_pkg::ADDR_PROG;
				wdata_r <= wd;
			end else if (send_mask) begin
				addr_r <= impl_pkg::ADDR_MASK;
				wdata_r <= mask_out;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			blk_r <= impl_pkg::BLK_FOUR;
			cnt_r <= 4'h0;
			max_r <= 4'h0;
		end else if (send_prog && hdr) begin
			blk_r <= impl_pkg::pb_block(wd);
			max_r <= impl_pkg::pb_len(impl_pkg::pb_block(wd));
			cnt_r <= impl_pkg::pb_start(wd) + 4'h1;
		end else if (send_prog) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			loading_r <= 1'b0;
			err_r <= 1'b0;
			mask_r <= impl_pkg::MASK_RESET;
		end else begin
			if (send_prog) begin
				loading_r <= 1'b1;
			end else if (wr_take && sel_ctrl) begin
				loading_r <= avs_writedata[0];
			end
			if (wr_take && sel_prog && prog_bad) begin
				err_r <= 1'b1;
			end else if (wr_take && sel_ctrl && avs_writedata[1]) begin
				err_r <= 1'b0;
			end
			if (send_mask) begin
				mask_r <= mask_out;
			end
		end
	end

	// reads take one wait cycle so read data come from a register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rdclr_r <= 1'b0;
		end else begin
			rvalid_r <= rd_take;
			rdclr_r <= rd_take && sel_stat;
			if (rd_take) begin
				rdata_r <= rmux;
			end
		end
	end

	assign avs_readdata = rdata_r;
	assign link.wr = wr_r;
	assign link.rd_clr = rdclr_r;
	assign link.addr = addr_r;
	assign link.wdata = wdata_r;
endmodule : impl_host

// [tb/impl_link_properties.sv]
// concurrent checks on the host-device control link
`timescale 1ns/1ps
module impl_link_properties #(
	parameter int unsigned PROG_CYCLES = impl_pkg::PROG_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link signals
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] status,
	input wire logic idle,
	input wire logic irq_n
);
	localparam logic [15:0] EV_BITS = impl_pkg::SRC_MASK & 16'hFFFE;
	logic [15:0] mask_r;
	logic [15:0] low_cnt_r;
	wire mask_wr = wr && addr == impl_pkg::ADDR_MASK;
	wire prog_wr = wr && addr == impl_pkg::ADDR_PROG;
	wire [15:0] mask_nxt = mask_wr ? wdata : mask_r;
	// shadow of the mask as the device holds it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) mask_r <= 16'h0000;
		else mask_r <= mask_nxt;
	end
	// cycles the ready flag has stood low; long waits are counted, not unrolled
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) low_cnt_r <= 16'h0000;
		else if (status[0]) low_cnt_r <= 16'h0000;
		else low_cnt_r <= low_cnt_r + 16'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	master_gate_a: assert property (!irq_n |-> $past(mask_r[15]))
		else $error("irq low with master enable off");
	irq_raise_a: assert property (mask_r[15] && (status & mask_r & EV_BITS) != 16'h0000 |=> !irq_n)
		else $error("enabled pending event without irq");
	event_gate_a: assert property ((status & ~$past(status) & EV_BITS & ~$past(mask_r)) == 16'h0000)
		else $error("event latched with its mask bit clear");
	reserved_zero_a: assert property ((status & ~impl_pkg::SRC_MASK) == 16'h0000)
		else $error("reserved status bit set");
	ready_clear_a: assert property (prog_wr && status[0] && idle |=> !status[0])
		else $error("ready not cleared by program write");
	ready_time_a: assert property ($rose(status[0]) |-> low_cnt_r == 16'(PROG_CYCLES))
		else $error("ready not restored on time");
	ready_late_a: assert property (!status[0] |-> low_cnt_r < 16'(PROG_CYCLES))
		else $error("ready held low too long");
	ready_irq_a: assert property ($rose(status[0]) && mask_r[15] && mask_r[0] |-> ##2 !irq_n)
		else $error("ready rise gave no irq");
	wr_pulse_a: assert property (wr |=> !wr)
		else $error("link write longer than one cycle");
	test_addr_a: assert property (wr |-> addr != impl_pkg::ADDR_TEST)
		else $error("test address written");
	cover property (prog_wr && status[0]);
	cover property (!irq_n);
	cover property (mask_wr && wdata[15]);
endmodule : impl_link_properties

// [tb/irq_mask_and_program_loader_tb.sv]
// bench joining host and device ends over the control link
`timescale 1ns/1ps
module irq_mask_and_program_loader_tb;
	// short program time keeps the run brief
	localparam int unsigned PC = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic rx_en = 1'b0;
	logic tx_en = 1'b0;
	logic aux_en = 1'b0;
	logic [7:0] ev = 8'h00;
	logic [2:0] rd_block = 3'h0;
	logic [3:0] rd_word = 4'h0;
	logic [15:0] rd_data;
	logic [31:0] q;
	int failures = 0;
	int checks_done = 0;
	always #2 clk = ~clk;
	impl_link_if lnk();
	impl_device #(.PROG_CYCLES(PC)) i_impl_device(.clk(clk), .rstn(rstn), .link(lnk),
		.rx_enable(rx_en), .tx_enable(tx_en), .aux_enable(aux_en), .tone_detect(ev[0]),
		.aux_converter_two(ev[1]), .aux_converter_one(ev[2]), .modem_tx_end(ev[3]),
		.modem_word_req(ev[4]), .crc_fail(ev[5]), .rate_2400_detect(ev[6]),
		.rate_1200_detect(ev[7]), .rd_block(rd_block), .rd_word(rd_word), .rd_data(rd_data),
		.mask_value(), .loader_busy());
	impl_host i_impl_host(.clk(clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(lnk));
	impl_link_properties #(.PROG_CYCLES(PC)) i_impl_link_properties(.clk(clk), .rstn(rstn),
		.wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .status(lnk.status),
		.idle(lnk.idle), .irq_n(lnk.irq_n));
	task stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// request held until the edge that sees waitrequest low; data taken there
	task av(input logic rd, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 2000) begin
			n++;
			@(posedge clk);
		end
		if (n >= 2000) begin
			failures++;
			$display("BAD %0t bus wait timed out", $time);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av
	task pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : pulse
	task rb(input logic [2:0] b, input logic [3:0] w, input logic [15:0] e);
		@(posedge clk);
		rd_block <= b;
		rd_word <= w;
		repeat (2) @(posedge clk);
		#1;
		chk(32'(rd_data), 32'(e));
	endtask : rb
	task t_events;
		logic [15:0] m;
		for (int i = 0; i < 8; i++) begin
			m = 16'h0001 << ((i == 0) ? 12 : 10 - i);
			av(1'b0, impl_pkg::HR_MASK, 32'(m));
			pulse(i);
			chk(32'(lnk.irq_n), 32'h1);
			av(1'b1, impl_pkg::HR_STAT, 32'h0);
			chk(32'(q[15:0]), 32'(m | 16'h0001));
			av(1'b0, impl_pkg::HR_MASK, 32'h8000);
			pulse(i);
			av(1'b1, impl_pkg::HR_STAT, 32'h0);
			chk(32'(q[15:0]), 32'h1);
			av(1'b0, impl_pkg::HR_MASK, 32'(m | 16'h8000));
			pulse(i);
			chk(32'(lnk.irq_n), 32'h0);
			av(1'b1, impl_pkg::HR_STAT, 32'h0);
			repeat (4) @(posedge clk);
			#1;
			chk(32'(lnk.irq_n), 32'h1);
		end
		av(1'b1, impl_pkg::HR_MASK, 32'h0);
		chk(32'(q[15:0]), 32'h8008);
		av(1'b1, 4'h2, 32'h0);
		chk(q, 32'h0);
	endtask : t_events
	task t_prog;
		int n;
		n = 0;
		av(1'b0, impl_pkg::HR_MASK, 32'h8001);
		av(1'b0, impl_pkg::HR_PROG, 32'hC123);
		@(posedge clk);
		#1;
		chk(32'(lnk.status[0]), 32'h0);
		while (lnk.status[0] !== 1'b1 && n < 200) begin
			n++;
			@(posedge clk);
		end
		chk(32'(lnk.status[0]), 32'h1);
		repeat (2) @(posedge clk);
		#1;
		chk(32'(lnk.irq_n), 32'h0);
		av(1'b0, impl_pkg::HR_PROG, 32'h4111);
		av(1'b0, impl_pkg::HR_PROG, 32'h4222);
		av(1'b0, impl_pkg::HR_PROG, 32'hF4AA);
		av(1'b0, impl_pkg::HR_PROG, 32'h0BCD);
		av(1'b1, impl_pkg::HR_STAT, 32'h0);
		chk(32'(q[20]), 32'h1);
		av(1'b0, impl_pkg::HR_CTRL, 32'h3);
		av(1'b0, impl_pkg::HR_PROG, 32'h8005);
		av(1'b0, impl_pkg::HR_MASK, 32'h9001);
		av(1'b1, impl_pkg::HR_MASK, 32'h0);
		chk(32'(q[15:0]), 32'h8001);
		// rx rises while the word is on the link, so only the device can refuse it
		av(1'b0, impl_pkg::HR_PROG, 32'h0777);
		rx_en <= 1'b1;
		@(posedge clk);
		#1;
		chk(32'(lnk.status[0]), 32'h1);
		av(1'b0, impl_pkg::HR_PROG, 32'h0888);
		av(1'b1, impl_pkg::HR_STAT, 32'h0);
		chk(32'(q[20]), 32'h1);
		rx_en <= 1'b0;
		av(1'b0, impl_pkg::HR_CTRL, 32'h3);
		aux_en <= 1'b1;
		av(1'b0, impl_pkg::HR_PROG, 32'h0999);
		av(1'b1, impl_pkg::HR_STAT, 32'h0);
		chk(32'({q[20], q[17]}), 32'h3);
		aux_en <= 1'b0;
		repeat (PC + 4) @(posedge clk);
		rb(3'h0, 4'h0, 16'hC123);
		rb(3'h0, 4'h2, 16'h4222);
		rb(3'h0, 4'h3, 16'h0000);
		rb(3'h3, 4'hB, 16'hF4AA);
		rb(3'h3, 4'h0, 16'h0000);
		rb(3'h4, 4'h0, 16'h8005);
		rb(3'h4, 4'h1, 16'h0000);
	endtask : t_prog
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_events;
		t_prog;
		stop_test;
	end
	// watchdog well beyond the expected few hundred cycles
	initial begin
		#400000;
		failures++;
		stop_test;
	end
endmodule : irq_mask_and_program_loader_tb
